// ### logic/cmc_mode_control.sv
// Operating mode control and status of the CAN controller, AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
`include "cmc_defines.svh"

// Overview of operation
// (RL1) With auto wakeup set, bus activity ends sleep without software action.
// (RL2) Retransmit disable bit 4: 0 retries failed frames, 1 sends once.
// (RL3) Overwrite disable bit 3: 0 overwrites full FIFO, 1 drops new frame.
// (RL4) Transmit order bit 2: 0 lowest identifier first, 1 queue order.
// (RL5) Sleep request bit 1 enters sleep only after current frame finishes.
// (RL6) Sleep request cleared by software write, or by hardware on auto wakeup.
// (RL7) Init request bit 0: write 1 requests init mode, 0 releases it.
// (RL8) Status bit 10 last sampled receive pin, bit 11 receive level, read only.
// (RL9) Status bit 9 reads 1 while receiving a frame.
// (RL10) Status bit 8 reads 1 while transmitting a frame.
// (RL11) Sleep entry flag, status bit 4, set on entering sleep.
// (RL12) Sleep entry flag cleared by hardware outside sleep, or by writing 1.
// (RL13) Wakeup flag, status bit 3, set on bus activity during sleep.
// (RL14) Wakeup flag cleared only by software writing 1.
// (RL15) Sleep state set on entry; cleared after 11 recessive bits on leaving.
// (RL16) Init state set on entry; cleared after 11 recessive bits on release.
// (RL17) Error flag set by enabled error conditions or codes 1 to 6; write 1 clears.
// (RL18) Writing 0 keeps write-one-to-clear flags; read-only status writes ignored.
module cmc_mode_control
  import cmc_pkg::*;
#(
  parameter int IDLE_BITS = `CMC_IDLE_BITS
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Bus side
  input  wire logic        rx_pin,
  input  wire logic        bit_tick,
  // Protocol engine side
  input  wire logic        frame_rx_busy,
  input  wire logic        frame_tx_busy,
  input  wire cmc_err_t    err_in,
  output cmc_ctrl_t        ctrl_out,
  output cmc_mode_t        mode_out,
  // Interrupt
  output logic             irq
);

  initial begin
    if (IDLE_BITS < 1 || IDLE_BITS > 255) begin
      $error("IDLE_BITS out of range");
    end
  end

  localparam int CW = $clog2(IDLE_BITS + 1);

  cmc_ctrl_t   ctrl_reg;
  cmc_mode_t   mode_reg;
  cmc_mode_t   mode_next;
  logic        from_sleep_reg;
  logic [CW-1:0] idle_cnt_reg;
  logic        rx_lvl_reg;
  logic        rx_last_reg;
  logic        rx_prev_reg;
  logic        rxing_reg;
  logic        txing_reg;
  logic        slp_flag_reg;
  logic        wake_flag_reg;
  logic        err_flag_reg;
  logic [2:0]  mask_reg;
  logic        wr_pend_reg;
  logic [7:0]  addr_reg;
  logic        busy;
  logic        activity;
  logic        auto_wake;
  logic        idle_done;
  logic        sleep_state;
  logic        init_state;
  logic        err_event;
  logic        wr_ctl;
  logic        wr_stat;
  logic        wr_mask;
  logic        acc;
  logic [31:0] status_word;

  //////////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign acc       = hsel && htrans[1] && hready;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else begin
      wr_pend_reg <= acc && hwrite;
      addr_reg    <= haddr;
    end
  end

  assign wr_ctl  = wr_pend_reg && (addr_reg == `CMC_CTL_OFS);
  assign wr_stat = wr_pend_reg && (addr_reg == `CMC_STAT_OFS);
  assign wr_mask = wr_pend_reg && (addr_reg == `CMC_MASK_OFS);

  // Read data is captured in the address phase; unmapped addresses read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (acc && !hwrite) begin
      case (haddr)
        `CMC_CTL_OFS:  hrdata <= {26'h0000000, ctrl_reg};
        `CMC_STAT_OFS: hrdata <= status_word;
        `CMC_MASK_OFS: hrdata <= {27'h0000000, mask_reg, 2'b00};
        default:       hrdata <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Bus observation

  assign busy      = frame_rx_busy || frame_tx_busy;
  // A dominant edge on the line is the wakeup trigger
  assign activity  = rx_prev_reg && !rx_lvl_reg;
  assign auto_wake = (mode_reg == ST_SLEEP) && activity && ctrl_reg.auto_wakeup;
  assign idle_done = bit_tick && rx_lvl_reg && (idle_cnt_reg == CW'(IDLE_BITS - 1));

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_lvl_reg  <= 1'b1;
      rx_prev_reg <= 1'b1;
      rx_last_reg <= 1'b1;
    end else begin
      rx_lvl_reg  <= rx_pin;                        // RL8
      rx_prev_reg <= rx_lvl_reg;
      if (bit_tick) begin
        rx_last_reg <= rx_lvl_reg;                  // RL8
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rxing_reg <= 1'b0;
      txing_reg <= 1'b0;
    end else begin
      rxing_reg <= frame_rx_busy;                   // RL9
      txing_reg <= frame_tx_busy;                   // RL10
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control register

  // A hardware wakeup clear beats a simultaneous software write of the request
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl_reg <= cmc_ctrl_t'(`CMC_CTL_RST);
    end else begin
      if (wr_ctl) begin
        ctrl_reg <= cmc_ctrl_t'(hwdata[`CMC_CTL_WIDTH-1:0]);  // RL7
      end
      if (auto_wake) begin
        ctrl_reg.sleep_request <= 1'b0;             // RL6
      end
    end
  end

  assign ctrl_out = ctrl_reg;                       // RL2 RL3 RL4

  //////////////////////////////////////////////////////////////////////////////
  // Mode sequencing

  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      ST_NORMAL: begin
        if (!busy && ctrl_reg.init_request) begin
          mode_next = ST_INIT;                      // RL7
        end else if (!busy && ctrl_reg.sleep_request) begin
          mode_next = ST_SLEEP;                     // RL5
        end
      end
      ST_SLEEP: begin
        if (ctrl_reg.init_request) begin
          mode_next = ST_INIT;
        end else if (!ctrl_reg.sleep_request || auto_wake) begin
          mode_next = ST_SYNC;                      // RL1
        end
      end
      ST_INIT: begin
        if (!ctrl_reg.init_request) begin
          mode_next = ctrl_reg.sleep_request ? ST_SLEEP : ST_SYNC;
        end
      end
      ST_SYNC: begin
        if (ctrl_reg.init_request) begin
          mode_next = ST_INIT;
        end else if (ctrl_reg.sleep_request) begin
          mode_next = ST_SLEEP;
        end else if (idle_done) begin
          mode_next = ST_NORMAL;                    // RL15 RL16
        end
      end
      default: mode_next = ST_SLEEP;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg       <= ST_SLEEP;
      from_sleep_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      if (mode_reg != ST_SYNC) begin
        from_sleep_reg <= (mode_reg == ST_SLEEP);
      end
    end
  end

  // Any dominant bit restarts the count of recessive bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= '0;
    end else if (mode_reg != ST_SYNC || (bit_tick && !rx_lvl_reg) || idle_done) begin
      idle_cnt_reg <= '0;
    end else if (bit_tick) begin
      idle_cnt_reg <= idle_cnt_reg + CW'(1);        // RL15 RL16
    end
  end

  assign mode_out    = mode_reg;
  assign sleep_state = (mode_reg == ST_SLEEP) || (mode_reg == ST_SYNC && from_sleep_reg);
  assign init_state  = (mode_reg == ST_INIT) || (mode_reg == ST_SYNC && !from_sleep_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Sticky status flags, set wins over clear

  assign err_event = (err_in.bus_off && err_in.bus_off_en) ||
                     (err_in.passive && err_in.passive_en) ||
                     (err_in.warning && err_in.warning_en) ||
                     (err_in.code_en && err_in.error_code != 3'h0 && err_in.error_code != 3'h7);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      slp_flag_reg <= 1'b0;
    end else if (mode_next == ST_SLEEP && mode_reg != ST_SLEEP) begin
      slp_flag_reg <= 1'b1;                         // RL11
    end else if (!sleep_state || (wr_stat && hwdata[`CMC_ST_SLPF])) begin
      slp_flag_reg <= 1'b0;                         // RL12 RL18
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_flag_reg <= 1'b0;
    end else if (mode_reg == ST_SLEEP && activity) begin
      wake_flag_reg <= 1'b1;                        // RL13
    end else if (wr_stat && hwdata[`CMC_ST_WAKEF]) begin
      wake_flag_reg <= 1'b0;                        // RL14 RL18
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_flag_reg <= 1'b0;
    end else if (err_event) begin
      err_flag_reg <= 1'b1;                         // RL17
    end else if (wr_stat && hwdata[`CMC_ST_ERRF]) begin
      err_flag_reg <= 1'b0;                         // RL17 RL18
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mask_reg <= `CMC_MASK_RST;
    end else if (wr_mask) begin
      mask_reg <= hwdata[`CMC_ST_SLPF:`CMC_ST_ERRF];
    end
  end

  always_comb begin
    status_word                 = 32'h00000000;
    status_word[`CMC_ST_INIT]   = init_state;      // RL16
    status_word[`CMC_ST_SLEEP]  = sleep_state;     // RL15
    status_word[`CMC_ST_ERRF]   = err_flag_reg;
    status_word[`CMC_ST_WAKEF]  = wake_flag_reg;
    status_word[`CMC_ST_SLPF]   = slp_flag_reg;
    status_word[`CMC_ST_TXING]  = txing_reg;       // RL10
    status_word[`CMC_ST_RXING]  = rxing_reg;       // RL9
    status_word[`CMC_ST_RX_LAST_SAMPLE] = rx_last_reg;     // RL8
    status_word[`CMC_ST_RXLVL]  = rx_lvl_reg;      // RL8
  end

  // A set mask bit silences its flag; reset leaves every flag able to interrupt
  assign irq = |({slp_flag_reg, wake_flag_reg, err_flag_reg} & ~mask_reg);

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_sleep_waits_frame: assert property (@(posedge clk_sys) disable iff (rst) // RL5
    (mode_reg == ST_NORMAL && busy) |=> mode_reg != ST_SLEEP)
    else $error("sleep entered during a frame");

  a_auto_wake_exit: assert property (@(posedge clk_sys) disable iff (rst) // RL1
    auto_wake |=> (mode_reg != ST_SLEEP && !ctrl_reg.sleep_request))
    else $error("auto wakeup did not leave sleep");

  a_init_enter: assert property (@(posedge clk_sys) disable iff (rst) // RL7
    (mode_reg == ST_NORMAL && ctrl_reg.init_request && !busy) |=> init_state)
    else $error("init mode not entered");

  a_idle_exit_count: assert property (@(posedge clk_sys) disable iff (rst) // RL15
    ($past(mode_reg) == ST_SYNC && mode_reg == ST_NORMAL) |->
      ($past(idle_cnt_reg) == CW'(IDLE_BITS - 1) && $past(bit_tick) && $past(rx_lvl_reg)))
    else $error("normal mode reached without recessive idle");

  a_slp_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // RL11
    $rose(mode_reg == ST_SLEEP) |-> slp_flag_reg)
    else $error("sleep entry flag not set");

  a_slp_flag_clr: assert property (@(posedge clk_sys) disable iff (rst) // RL12
    (!sleep_state && mode_next != ST_SLEEP) |=> !slp_flag_reg)
    else $error("sleep entry flag kept outside sleep");

  a_wake_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // RL13
    (mode_reg == ST_SLEEP && activity) |=> wake_flag_reg)
    else $error("wakeup flag not set");

  a_wake_flag_hold: assert property (@(posedge clk_sys) disable iff (rst) // RL14
    (wake_flag_reg && !(wr_stat && hwdata[`CMC_ST_WAKEF])) |=> wake_flag_reg)
    else $error("wakeup flag lost without software clear");

  a_err_flag_set: assert property (@(posedge clk_sys) disable iff (rst) // RL17
    err_event |=> err_flag_reg)
    else $error("error flag not set");

  a_rx_level: assert property (@(posedge clk_sys) disable iff (rst) // RL8
    ##1 status_word[`CMC_ST_RXLVL] == $past(rx_pin))
    else $error("receive level does not follow the pin");

  c_enter_sleep: cover property (@(posedge clk_sys) disable iff (rst)
    mode_reg == ST_NORMAL ##1 mode_reg == ST_SLEEP);

  c_auto_wake: cover property (@(posedge clk_sys) disable iff (rst) auto_wake);

  c_reach_normal: cover property (@(posedge clk_sys) disable iff (rst)
    mode_reg == ST_SYNC ##1 mode_reg == ST_NORMAL);

  c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));

endmodule
`default_nettype wire

// ### logic/cmc_defines.svh
// Offsets, field positions, reset values and timing counts of the mode control block
`ifndef CMC_DEFINES_SVH
`define CMC_DEFINES_SVH

// Register byte offsets
`define CMC_CTL_OFS        8'h00
`define CMC_STAT_OFS       8'h04
`define CMC_MASK_OFS       8'h10

// Control field width and reset value
`define CMC_CTL_WIDTH      6
`define CMC_CTL_RST        6'h02

// Status field positions
`define CMC_ST_INIT        0
`define CMC_ST_SLEEP       1
`define CMC_ST_ERRF        2
`define CMC_ST_WAKEF       3
`define CMC_ST_SLPF        4
`define CMC_ST_TXING       8
`define CMC_ST_RXING       9
`define CMC_ST_RX_LAST_SAMPLE      10
`define CMC_ST_RXLVL       11
`define CMC_STAT_RST       32'h00000c02

// Mask register: same layout as the sticky status flags
`define CMC_MASK_RST       3'h0

// Recessive bits needed before normal operation
`define CMC_IDLE_BITS      11

`endif

// ### logic/cmc_pkg.sv
// Types shared by the mode control block
package cmc_pkg;

  // Control bits in register order, bit 5 down to bit 0
  typedef struct packed {
    logic auto_wakeup;
    logic retransmit_disable;
    logic rx_overwrite_disable;
    logic tx_order_select;
    logic sleep_request;
    logic init_request;
  } cmc_ctrl_t;

  // Error conditions reported by the error counter logic, with their enables
  typedef struct packed {
    logic       bus_off;
    logic       passive;
    logic       warning;
    logic       bus_off_en;
    logic       passive_en;
    logic       warning_en;
    logic       code_en;
    logic [2:0] error_code;
  } cmc_err_t;

  typedef enum logic [1:0] {
    ST_NORMAL,
    ST_SLEEP,
    ST_INIT,
    ST_SYNC
  } cmc_mode_t;

endpackage

// ### verification/cmc_bus_model.sv
// Bus side model: transceiver receive line and bit sample ticks
`timescale 1ns/1ps
`default_nettype none

module cmc_bus_model #(
  parameter int TICK_DIV = 4
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Dominant request from the bench
  input  wire logic dom,
  // Bus outputs
  output logic      rx_pin,
  output logic      bit_tick
);
  int cnt;

  // Transceiver pulls the line recessive unless a node drives dominant
  assign rx_pin = !dom;

  // Sample point pulse, one cycle per bit time
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt      <= 0;
      bit_tick <= 1'b0;
    end else begin
      cnt      <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
      bit_tick <= (cnt == TICK_DIV - 1);
    end
  end
endmodule

`default_nettype wire

// ### verification/test_can_mode_control_status.sv
// Register level test of the mode control block
`timescale 1ns/1ps
`default_nettype none

module test_can_mode_control_status
  import cmc_pkg::*;
;
  logic        clk_sys, rst, dom, hwrite, hreadyout, hresp;
  logic        rx_pin, bit_tick, rx_busy, tx_busy, irq;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, q;
  cmc_err_t    err_in;
  cmc_ctrl_t   ctrl_out;
  cmc_mode_t   mode_out;
  int          error_cnt, checked, cyc;

  always #4 clk_sys = ~clk_sys;

  cmc_bus_model #(.TICK_DIV(4)) bus (.clk_sys(clk_sys), .rst(rst), .dom(dom),
    .rx_pin(rx_pin), .bit_tick(bit_tick));

  // Short idle count keeps the resynchronisation waits brief
  cmc_mode_control #(.IDLE_BITS(3)) uut (.clk_sys(clk_sys), .rst(rst), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_pin(rx_pin), .bit_tick(bit_tick), .frame_rx_busy(rx_busy),
    .frame_tx_busy(tx_busy), .err_in(err_in), .ctrl_out(ctrl_out),
    .mode_out(mode_out), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (error_cnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wait_mode(input cmc_mode_t m);
    int n;
    n = 0;
    while (mode_out !== m && n < 300) begin
      @(posedge clk_sys);
      n++;
    end
    chk({30'h0, mode_out}, {30'h0, m});
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    dom = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rx_busy = 1'b0;
    tx_busy = 1'b0;
    err_in = '0;
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rd(8'h04, 32'h00000c02);
    rd(8'h00, 32'h00000002);
    rd(8'h10, 32'h00000000);
    wr(8'h08, 32'hffffffff);
    rd(8'h08, 32'h00000000);
    // Leave sleep with the three policy bits set
    wr(8'h00, 32'h0000001c);
    rd(8'h00, 32'h0000001c);
    chk({26'h0, ctrl_out}, 32'h1c);
    wait_mode(ST_NORMAL);
    rd(8'h04, 32'h00000c00);
    wr(8'h00, 32'h00000001);
    wait_mode(ST_INIT);
    rd(8'h04, 32'h00000c01);
    wr(8'h00, 32'h00000000);
    rd(8'h04, 32'h00000c01);
    wait_mode(ST_NORMAL);
    rd(8'h04, 32'h00000c00);
    // Sleep request waits for the frame in flight
    tx_busy <= 1'b1;
    wr(8'h00, 32'h00000002);
    repeat (10) @(posedge clk_sys);
    rd(8'h04, 32'h00000d00);
    tx_busy <= 1'b0;
    wait_mode(ST_SLEEP);
    rd(8'h04, 32'h00000c12);
    chk({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h00000010);
    // The mask lands at the edge that ends the write; look one edge later
    @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0);
    wr(8'h10, 32'h00000000);
    wr(8'h04, 32'h00000f03);
    rd(8'h04, 32'h00000c12);
    wr(8'h04, 32'h00000010);
    rd(8'h04, 32'h00000c02);
    // Re-enter sleep so that wakeup must clear the entry flag in hardware
    wr(8'h00, 32'h00000020);
    wait_mode(ST_NORMAL);
    wr(8'h00, 32'h00000022);
    wait_mode(ST_SLEEP);
    rd(8'h04, 32'h00000c12);
    // Bus activity wakes the controller without software
    dom <= 1'b1;
    repeat (6) @(posedge clk_sys);
    dom <= 1'b0;
    wait_mode(ST_NORMAL);
    rd(8'h00, 32'h00000020);
    rd(8'h04, 32'h00000c08);
    chk({31'h0, irq}, 32'h1);
    wr(8'h04, 32'h00000000);
    rd(8'h04, 32'h00000c08);
    wr(8'h04, 32'h00000008);
    rd(8'h04, 32'h00000c00);
    // Dominant line while a frame is received
    dom <= 1'b1;
    rx_busy <= 1'b1;
    repeat (10) @(posedge clk_sys);
    rd(8'h04, 32'h00000200);
    dom <= 1'b0;
    rx_busy <= 1'b0;
    repeat (10) @(posedge clk_sys);
    // Every error code, enabled, then the enabled and disabled conditions
    for (int i = 0; i < 12; i++) begin
      if (i < 8) begin
        err_in <= {7'h01, i[2:0]};
      end else begin
        err_in <= (i == 8) ? 10'h240 : (i == 9) ? 10'h120 : (i == 10) ? 10'h090 : 10'h380;
      end
      @(posedge clk_sys);
      err_in <= '0;
      rd(8'h04, (i inside {[1:6], [8:10]}) ? 32'h00000c04 : 32'h00000c00);
      wr(8'h04, 32'h00000004);
      rd(8'h04, 32'h00000c00);
    end
    complete_run();
  end
endmodule

`default_nettype wire
